// >>> design/bph_pkg.sv
// Behaviour
// RQ1 - Eight lines, each independently set as input or output by software.
// RQ2 - One port-wide bit picks push-pull or open-drain for all output lines.
// RQ3 - One port-wide bit switches every output buffer to reduced-emission drive.
// RQ4 - Reset leaves every line an input with all output drivers off.
// RQ5 - Software may put port transfers under handshake control instead of direct.
// RQ6 - Handshake uses one neighbour input line and one neighbour output line.
// RQ7 - Handshake direction follows the direction set for the top port line.
// RQ8 - Handshake input line only receives; handshake output line always drives.
// RQ9 - Interlocked: data plus strobe, acceptance, strobe released before next.
package bph_pkg;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int unsigned BPH_WIDTH = 8;
	localparam int unsigned BPH_TOP_BIT = 7;
	localparam logic [7:0] BPH_DIR_RESET = 8'hFF; // All lines input
	localparam logic [7:0] BPH_DATA_RESET = 8'h00;
	localparam logic BPH_OD_RESET = 1'h0; // Push-pull
	localparam logic BPH_EMI_RESET = 1'h0; // Standard drive
	localparam logic BPH_HS_RESET = 1'h0; // Direct access

	// ------------------------------------------------------------
	// Handshake sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BPH_IDLE = 2'b00,
		BPH_OUT_STROBE = 2'b01,
		BPH_OUT_RELEASE = 2'b10,
		BPH_IN_ACK = 2'b11
	} bph_state_t;

endpackage

// >>> design/bph_sync.sv
// ------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ------------------------------------------------------------
module bph_sync
	import bph_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second stage
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule // bph_sync

// >>> design/bph_port.sv
// ------------------------------------------------------------
// Bidirectional port with optional interlocked handshake
// ------------------------------------------------------------
module bph_port
	import bph_pkg::*;
#(
	parameter int unsigned WIDTH = BPH_WIDTH
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] dir_i,
	input wire logic open_drain_i,
	input wire logic low_emi_i,
	input wire logic handshake_en_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic wr_strobe_i,
	input wire logic rd_ack_i,
	output logic [WIDTH-1:0] rd_data_o,
	output logic rx_valid_o,
	output logic tx_busy_o,
	output logic low_emi_o,
	input wire logic [WIDTH-1:0] port_lines_i,
	output logic [WIDTH-1:0] port_lines_o,
	output logic [WIDTH-1:0] port_lines_oe_n_o,
	input wire logic handshake_input_line_i,
	output logic handshake_output_line_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] dir;
		logic od;
		logic emi;
		logic hs_en;
		logic [WIDTH-1:0] out;
		logic [WIDTH-1:0] rd;
		logic rx_valid;
		logic hs_out;
		bph_state_t state;
	} bph_regs_t;

	bph_regs_t st;
	bph_regs_t next_st;
	logic [WIDTH-1:0] pins_s;
	logic hs_in_s;
	logic top_is_out;

	// Pins cross into the core clock through two flops
	bph_sync #(.WIDTH(WIDTH + 1)) u_sync (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.async_i({handshake_input_line_i, port_lines_i}),
		.sync_o({hs_in_s, pins_s})
	);

	assign top_is_out = ~st.dir[BPH_TOP_BIT]; // [RQ7]

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.dir = dir_i; // [RQ1]
		next_st.od = open_drain_i; // [RQ2]
		next_st.emi = low_emi_i; // [RQ3]
		next_st.hs_en = handshake_en_i; // [RQ5]
		// Clear first so a same-cycle capture wins over the read ack
		if (rd_ack_i) begin
			next_st.rx_valid = 1'b0;
		end
		if (!st.hs_en) begin
			// Direct access; a dropped mode abandons any handshake
			next_st.state = BPH_IDLE;
			next_st.hs_out = 1'b0;
			next_st.rx_valid = 1'b0;
			next_st.rd = (pins_s & st.dir) | (st.out & ~st.dir);
			if (wr_strobe_i) begin
				next_st.out = wr_data_i;
			end
		end else begin
			case (st.state)
				BPH_IDLE: begin
					if (top_is_out && wr_strobe_i) begin
						// Present data and raise strobe together
						next_st.out = wr_data_i; // [RQ9]
						next_st.hs_out = 1'b1; // [RQ7]
						next_st.state = BPH_OUT_STROBE;
					end else if (!top_is_out && hs_in_s && !st.rx_valid) begin
						// Capture while holding off a full buffer
						next_st.rd = pins_s; // [RQ7]
						next_st.rx_valid = 1'b1;
						next_st.hs_out = 1'b1; // [RQ6]
						next_st.state = BPH_IN_ACK;
					end
				end
				BPH_OUT_STROBE: begin
					if (hs_in_s) begin
						next_st.hs_out = 1'b0; // [RQ9]
						next_st.state = BPH_OUT_RELEASE;
					end
				end
				BPH_OUT_RELEASE: begin
					if (!hs_in_s) begin
						next_st.state = BPH_IDLE; // [RQ9]
					end
				end
				BPH_IN_ACK: begin
					if (!hs_in_s) begin
						next_st.hs_out = 1'b0; // [RQ9]
						next_st.state = BPH_IDLE;
					end
				end
				default: begin
					next_st.state = BPH_IDLE;
					next_st.hs_out = 1'b0;
				end
			endcase
		end
		// Dropping the mode aborts at once, so no strobe outlives it
		if (!handshake_en_i) begin
			next_st.state = BPH_IDLE;
			next_st.hs_out = 1'b0; // [RQ5]
			next_st.rx_valid = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st.dir <= BPH_DIR_RESET; // [RQ4]
			st.od <= BPH_OD_RESET;
			st.emi <= BPH_EMI_RESET;
			st.hs_en <= BPH_HS_RESET;
			st.out <= BPH_DATA_RESET;
			st.rd <= BPH_DATA_RESET;
			st.rx_valid <= 1'b0;
			st.hs_out <= 1'b0;
			st.state <= BPH_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Open drain releases a one rather than driving it high
	assign port_lines_oe_n_o = st.dir | ({WIDTH{st.od}} & st.out); // [RQ2]
	assign port_lines_o = st.out;
	assign low_emi_o = st.emi; // [RQ3]
	// Neighbour line is a fixed output, driven in every mode
	assign handshake_output_line_o = st.hs_out; // [RQ8]
	assign rd_data_o = st.rd;
	assign rx_valid_o = st.rx_valid;
	assign tx_busy_o = (st.state == BPH_OUT_STROBE) ||
		(st.state == BPH_OUT_RELEASE);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	property p_reset_input;
		@(posedge core_clk_i) disable iff (1'b0)
		srst_i |=> (&port_lines_oe_n_o) && !handshake_output_line_o;
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("not input after reset"); // [RQ4]

	property p_input_undriven;
		&(port_lines_oe_n_o | ~st.dir);
	endproperty
	a_input_undriven: assert property (p_input_undriven) else $error("input line driven"); // [RQ1]

	property p_dir_follow;
		1'b1 |=> (st.dir == $past(dir_i)) &&
			((~port_lines_oe_n_o & $past(dir_i)) == '0);
	endproperty
	a_dir_follow: assert property (p_dir_follow) else $error("direction lag"); // [RQ1]

	property p_od_no_high;
		st.od |-> &(port_lines_oe_n_o | ~port_lines_o);
	endproperty
	a_od_no_high: assert property (p_od_no_high) else $error("open drain drove high"); // [RQ2]

	property p_pp_drive;
		!st.od |-> ((port_lines_oe_n_o & ~st.dir) == '0);
	endproperty
	a_pp_drive: assert property (p_pp_drive) else $error("push-pull not driving"); // [RQ2]

	property p_emi;
		1'b1 |=> low_emi_o == $past(low_emi_i);
	endproperty
	a_emi: assert property (p_emi) else $error("emission mode lag"); // [RQ3]

	property p_direct_quiet;
		!st.hs_en |-> !handshake_output_line_o;
	endproperty
	a_direct_quiet: assert property (p_direct_quiet) else $error("strobe in direct mode"); // [RQ5]

	sequence s_out_start;
		st.hs_en && handshake_en_i && st.state == BPH_IDLE && top_is_out &&
			wr_strobe_i;
	endsequence
	sequence s_out_presented;
		##1 handshake_output_line_o && port_lines_o == $past(wr_data_i);
	endsequence
	property p_out_strobe;
		s_out_start |-> s_out_presented;
	endproperty
	a_out_strobe: assert property (p_out_strobe) else $error("output strobe missing"); // [RQ7]

	sequence s_accepted;
		st.state == BPH_OUT_STROBE && hs_in_s && handshake_en_i;
	endsequence
	property p_release;
		s_accepted |=> !handshake_output_line_o ##1
			(tx_busy_o || st.state == BPH_IDLE);
	endproperty
	a_release: assert property (p_release) else $error("strobe not released"); // [RQ9]

	property p_in_ack;
		st.hs_en && handshake_en_i && st.state == BPH_IDLE && !top_is_out &&
			hs_in_s && !st.rx_valid |=> handshake_output_line_o && rx_valid_o &&
			rd_data_o == $past(pins_s);
	endproperty
	a_in_ack: assert property (p_in_ack) else $error("input ack missing"); // [RQ6]
endmodule // bph_port

// >>> test/bph_peer.sv
// ----------------------------------------
// Far-side peripheral: sends or accepts one byte per handshake
// ----------------------------------------
module bph_peer (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic slow_i,
	input wire logic [7:0] data_i,
	input wire logic hso_i,
	output logic [7:0] pins_o,
	output logic hsi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bounded wait, so a dead port cannot hang the peer
	task automatic wait_hso(input logic v);
		for (int i = 0; i < 60 && hso_i !== v; i++) @(posedge clk_i);
	endtask
	// Released bus shows the inverse, not a stale copy
	initial begin
		pins_o = 8'h00;
		hsi_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (send_i) begin
				pins_o <= data_i;
				repeat (3) @(posedge clk_i); // Data settles first
				hsi_o <= 1'b1;
				wait_hso(1'b1);
				hsi_o <= 1'b0;
				pins_o <= ~data_i;
				wait_hso(1'b0);
			end else if (hso_i) begin
				if (slow_i) repeat (6) @(posedge clk_i);
				hsi_o <= 1'b1;
				wait_hso(1'b0);
				hsi_o <= 1'b0;
			end else begin
				pins_o <= data_i;
			end
		end
	end
endmodule // bph_peer

// >>> test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bph_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
$display("unexpected t=%0t got %h exp %h", $time, a, b); end end
	logic core_clk_i = 1'b0, srst_i = 1'b1, od = 1'b0, emi = 1'b0, hs = 1'b0;
	logic ws = 1'b0, ra = 1'b0, send = 1'b0, slow = 1'b0;
	logic [7:0] dir = 8'hFF, wd = 8'h00, pd = 8'h00, w;
	logic [7:0] rd, plo, oen, pins, lvl;
	logic rv, busy, emio, hso, hsi;
	int failures = 0, checks_done = 0;
	// Pin level: design where it drives, peer elsewhere
	assign lvl = (oen & pins) | (~oen & plo);
	always #4 core_clk_i = ~core_clk_i;
	bph_port u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .dir_i(dir),
		.open_drain_i(od), .low_emi_i(emi), .handshake_en_i(hs),
		.wr_data_i(wd), .wr_strobe_i(ws), .rd_ack_i(ra), .rd_data_o(rd),
		.rx_valid_o(rv), .tx_busy_o(busy), .low_emi_o(emio),
		.port_lines_i(lvl), .port_lines_o(plo), .port_lines_oe_n_o(oen),
		.handshake_input_line_i(hsi), .handshake_output_line_o(hso));
	bph_peer u_peer (.clk_i(core_clk_i), .send_i(send), .slow_i(slow),
		.data_i(pd), .hso_i(hso), .pins_o(pins), .hsi_o(hsi));
	// Open-drain lines float on a one
	function automatic logic [7:0] exp_oe(logic [7:0] d, logic o, logic [7:0] v);
		return d | (~d & {8{o}} & v);
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait on rx_valid (sel=1) or tx_busy (sel=0)
	task automatic wait_for(logic sel, logic v);
		int i;
		for (i = 0; i < 80 && (sel ? rv : busy) !== v; i++) tick(1);
		if (i == 80) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic strobe_write(logic [7:0] v);
		@(posedge core_clk_i);
		wd <= v;
		ws <= 1'b1;
		@(posedge core_clk_i);
		ws <= 1'b0;
	endtask
	initial begin
		void'($urandom(32'he8c0));
		tick(11);
		`CHK(oen, 8'hFF)
		`CHK({hso, emio, plo}, 10'h000)
		@(posedge core_clk_i);
		srst_i <= 1'b0;
		// ----------------------------------------
		// Direct access, random direction and drive
		// ----------------------------------------
		for (int i = 0; i < 24; i++) begin
			@(posedge core_clk_i);
			dir <= i ? $urandom : 8'h00;
			od <= i ? $urandom : 1'b1;
			emi <= $urandom;
			pd <= $urandom;
			strobe_write(i ? $urandom : 8'hA5);
			tick(5);
			`CHK(plo, wd)
			`CHK(oen, exp_oe(dir, od, wd))
			`CHK(emio, emi)
			`CHK(rd, (dir & pd) | (~dir & wd))
		end
		$display("direct test done");
		// ----------------------------------------
		// Output handshake, top line an output
		// ----------------------------------------
		@(posedge core_clk_i);
		{hs, dir, od} <= {1'b1, 8'h00, 1'b0};
		for (int i = 0; i < 6; i++) begin
			w = $urandom;
			slow <= i[0];
			strobe_write(w);
			tick(1);
			`CHK({busy, hso, plo}, {2'b11, w})
			strobe_write(~w);
			wait_for(1'b0, 1'b0);
			`CHK({hso, plo}, {1'b0, w})
		end
		$display("output handshake test done");
		// ----------------------------------------
		// Input handshake, top line an input
		// ----------------------------------------
		@(posedge core_clk_i);
		dir <= 8'hFF;
		tick(4);
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk_i);
			pd <= $urandom;
			send <= 1'b1;
			wait_for(1'b1, 1'b1);
			send <= 1'b0;
			`CHK({hso, rd}, {1'b1, pd})
			tick(20);
			`CHK({hso, rv}, 2'b01)
			@(posedge core_clk_i);
			ra <= 1'b1;
			@(posedge core_clk_i);
			ra <= 1'b0;
			tick(1);
			`CHK(rv, 1'b0)
		end
		$display("input handshake test done");
		print_verdict();
	end
endmodule // tb
